//--- hdl/ecpp_defs.vh
// Constants of the extended-capabilities parallel port control block
`ifndef ECPP_DEFS_VH
`define ECPP_DEFS_VH
// ----------------------------------------------------------------
// Register offsets (address bits 10 and 2..0)
// ----------------------------------------------------------------
`define ECPP_OFS_DATA     11'h000
`define ECPP_OFS_STATUS   11'h001
`define ECPP_OFS_CONTROL  11'h002
`define ECPP_OFS_FIFO     11'h400
`define ECPP_OFS_CAPB     11'h401
`define ECPP_OFS_EXTCTL   11'h402
`define ECPP_OFS_EXTIDX   11'h403
`define ECPP_OFS_EXTDAT   11'h404
`define ECPP_OFS_EXTAUX   11'h405
// ----------------------------------------------------------------
// Second-level indices
// ----------------------------------------------------------------
`define ECPP_IDX_CTL0     8'h00
`define ECPP_IDX_CTL2     8'h02
`define ECPP_IDX_CTL4     8'h04
`define ECPP_IDX_SETUP0   8'h05
// ----------------------------------------------------------------
// Mode encodings
// ----------------------------------------------------------------
`define ECPP_MODE_SPP     3'h0
`define ECPP_MODE_PS2     3'h1
`define ECPP_MODE_COMPAT_FIFO_PORT   3'h2
`define ECPP_MODE_ECP     3'h3
`define ECPP_MODE_EPP     3'h4
`define ECPP_MODE_TEST    3'h6
`define ECPP_MODE_CONFIG  3'h7
`define ECPP_CFG_ECP_A    3'h4
`define ECPP_CFG_ECP_B    3'h7
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define ECPP_CTL_DIR      5
`define ECPP_XC_DMAEN     3
`define ECPP_XC_SVC       2
`define ECPP_SU_DEMAND    6
`define ECPP_CFG_INDEX    4
`define ECPP_RST_EXTCTL   8'h15
`define ECPP_RST_CONTROL  8'hC0
`define ECPP_PD_EXTLOW    3'h3
`define ECPP_CAPA_HIGH    4'h1
`define ECPP_CAPA_LOW     3'h4
// ----------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------
`define ECPP_FIFO_DEPTH   16
`define ECPP_BURST_MAX    6'd32
`define ECPP_DEMAND_CNT   3'd4
`define ECPP_SETTLE_NS    80
`define ECPP_CLK_NS       40
`define ECPP_SETTLE_CYC   ((`ECPP_SETTLE_NS + `ECPP_CLK_NS - 1) / `ECPP_CLK_NS)
`endif

//--- hdl/ecpp_fifo.v
// Sixteen-entry tagged byte FIFO shared by all FIFO ports
`timescale 1ns/100ps
`include "ecpp_defs.vh"
module ecpp_fifo (
	input  wire       core_clk,
	input  wire       reset,
	input  wire       clear,
	input  wire       push,
	input  wire [8:0] pushData,
	input  wire       pop,
	output wire [8:0] topData,
	output wire       empty,
	output wire       full,
	output wire [4:0] level
);
	reg  [8:0] store [0:`ECPP_FIFO_DEPTH-1];
	reg  [3:0] wrPtr;
	reg  [3:0] rdPtr;
	reg  [4:0] count;
	wire       doPush;
	wire       doPop;

	// Overrun and underrun are dropped so the flags do not move on them [RULE19]
	assign doPush  = push && !full;
	assign doPop   = pop && !empty;
	assign empty   = (count == 5'd0);
	assign full    = (count == 5'd16);
	assign level   = count;
	assign topData = store[rdPtr];

	always @(posedge core_clk) begin
		if (doPush) begin
			store[wrPtr] <= pushData; // [RULE23]
		end
	end

	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wrPtr <= 4'h0;
			rdPtr <= 4'h0;
			count <= 5'h00;
		end else if (clear) begin
			wrPtr <= 4'h0;
			rdPtr <= 4'h0;
			count <= 5'h00;
		end else begin
			if (doPush) begin
				wrPtr <= wrPtr + 4'h1;
			end
			if (doPop) begin
				rdPtr <= rdPtr + 4'h1;
			end
			if (doPush && !doPop) begin
				count <= count + 5'h01;
			end else if (doPop && !doPush) begin
				count <= count - 5'h01;
			end
		end
	end
endmodule

//--- hdl/ecpp_port.v
// Extended-capabilities parallel port: decode, FIFO, DMA, peripheral side
// How it works
// RULE1 - Mode comes from config strap at reset, then extended control bits 7-5. Code samples the strap every cycle, for ECP enable only.
// RULE2 - Software sets control low nibble to 0100 before enabling ECP.
// RULE3 - Software changes modes only via 000/001; direction only in 001.
// RULE4 - Software leaves modes 010/011 only once the FIFO is empty.
// RULE5 - Software enters 011, 010, 100 only with given control bits clear.
// RULE6 - Software leaves mode 100 only while status bit 7 reads one.
// RULE7 - Software clears direction bit in mode 100 before EPP cycles.
// RULE8 - Leaving 011 mid-read drops auto-feed, empties FIFO, stops expansion.
// RULE9 - Zero-wait indication on every ECP register access except control reads; code exempts extended control reads (402h) instead.
// RULE10 - Frozen clock: no DMA, only acknowledge interrupt, FIFO access ignored.
// RULE11 - Frozen clock: extended control bits 2..0 read 0,1,1; FIFO kept.
// RULE12 - Frozen clock starts no new peripheral cycle.
// RULE13 - Peripheral outputs inactive while ECP is disabled.
// RULE14 - Exit from 010/011 resets FIFO, DMA and expansion, even frozen.
// RULE15 - FIFO ports decode at 000h or 400h by mode and register.
// RULE16 - DMA enabled and service clear requests fill or drain by direction.
// RULE17 - At most 32 consecutive DMA cycles; terminal count stops requests.
// RULE18 - Demand DMA waits until four requests are pending.
// RULE19 - Full-FIFO writes dropped, empty reads undefined, flags unchanged.
// RULE20 - Invalid registers have no effect; legacy registers gone in ECP.
// RULE21 - Handshake lines ignored until driven data has settled.
// RULE22 - Index/data reach second-level registers when enabled by config.
// RULE23 - Sixteen-byte FIFO, either direction, one tag per byte.
// RULE24 - Direction bit zero drives data lines; one leaves them undriven. Code drives them in modes 000/010 whatever the bit, and not while ECP is off.
// RULE25 - Data register reads return live data lines in 000/001.
`timescale 1ns/100ps
`include "ecpp_defs.vh"
module ecpp_port (
	input  wire        core_clk,
	input  wire        reset,
	input  wire [7:0]  configMode,
	input  wire        baseAddr2,
	input  wire        baseAddr10,
	input  wire        clockFrozen,
	input  wire [10:0] hostAddr,
	input  wire [7:0]  hostWrData,
	input  wire        hostRd,
	input  wire        hostWr,
	input  wire        dmaAck,
	input  wire        dmaTc,
	output reg  [7:0]  hostRdData,
	output wire        zeroWaitIndication,
	output wire        dmaReq,
	output wire        ackIrqOnly,
	input  wire [7:0]  parallelDataLinesIn,
	output reg  [7:0]  parallelDataLinesOut,
	output wire        parallelDataLinesOe,
	input  wire        busyIn,
	input  wire        ackIn_n,
	input  wire        errIn_n,
	input  wire        selectIn,
	input  wire        paperEndIn,
	output wire        strobeOut_n,
	output wire        autoLineFeedLine_n,
	output wire        initOut_n,
	output wire        selectInOut_n
);
	// ----------------------------------------------------------------
	// Peripheral cycle states
	// ----------------------------------------------------------------
	localparam [2:0] ST_IDLE   = 3'd0;
	localparam [2:0] ST_SETTLE = 3'd1;
	localparam [2:0] ST_FWAIT  = 3'd2;
	localparam [2:0] ST_FDONE  = 3'd3;
	localparam [2:0] ST_BWAIT  = 3'd4;
	localparam [2:0] ST_BDONE  = 3'd5;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg        ecpEnabled;
	reg  [7:0] portData;
	reg  [7:0] portControl;
	reg  [7:0] extendedControl;
	reg  [7:0] extendedIndex;
	reg  [7:0] extendedAux;
	reg  [7:0] secondCtl0;
	reg  [7:0] secondCtl2;
	reg  [7:0] secondCtl4;
	reg  [7:0] portSetupZero;
	reg  [2:0] state;
	reg  [2:0] settleCnt;
	reg  [5:0] burstCnt;
	reg        burstStop;
	reg  [2:0] pendCnt;
	reg        dmaPhase;
	reg        strobeAct;
	reg        feedAct;
	reg  [7:0] rleCount;

	wire [2:0] mode;
	wire       dirBack;
	wire       fifoMode;
	wire       fifoIdle;
	wire       isEcpOfs;
	wire       secondOn;
	wire       fifoWrSel;
	wire       fifoRdSel;
	wire       fifoPush;
	wire       fifoPop;
	wire [8:0] fifoIn;
	wire [8:0] fifoTop;
	wire       fifoEmpty;
	wire       fifoFull;
	wire [4:0] fifoLevel;
	wire       fifoClear;
	wire       leaving;
	wire       wantDma;
	wire       perPush;
	wire       perPop;
	wire       hostFifoRd;
	wire       hostFifoWr;
	wire [7:0] statusByte;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function isFifoMode;
		input [2:0] m;
		begin
			isFifoMode = (m == `ECPP_MODE_COMPAT_FIFO_PORT) ||
				(m == `ECPP_MODE_ECP);
		end
	endfunction

	assign mode     = extendedControl[7:5];
	// Direction forced forward in modes 000 and 010
	assign dirBack  = portControl[`ECPP_CTL_DIR] &&
		(mode != `ECPP_MODE_SPP) && (mode != `ECPP_MODE_COMPAT_FIFO_PORT);
	assign fifoMode = isFifoMode(mode);
	assign fifoIdle = !ecpEnabled || clockFrozen;
	assign isEcpOfs = (hostAddr == `ECPP_OFS_DATA) ||
		(hostAddr == `ECPP_OFS_STATUS) ||
		(hostAddr == `ECPP_OFS_CONTROL) ||
		(hostAddr[10] && hostAddr[2:0] <= 3'h5 && hostAddr[9:3] == 7'h00);
	assign secondOn = configMode[`ECPP_CFG_INDEX] &&
		(baseAddr2 || baseAddr10); // [RULE22]

	// ----------------------------------------------------------------
	// FIFO decode
	// ----------------------------------------------------------------
	// Only the port valid for the mode and direction reaches the FIFO
	assign fifoWrSel = (hostAddr == `ECPP_OFS_DATA &&
		mode == `ECPP_MODE_ECP && !dirBack) ||
		(hostAddr == `ECPP_OFS_FIFO &&
		(mode == `ECPP_MODE_COMPAT_FIFO_PORT || mode == `ECPP_MODE_TEST ||
		(mode == `ECPP_MODE_ECP && !dirBack))); // [RULE15] [RULE20]
	assign fifoRdSel = hostAddr == `ECPP_OFS_FIFO &&
		(mode == `ECPP_MODE_TEST ||
		(mode == `ECPP_MODE_ECP && dirBack)); // [RULE15] [RULE20]
	// Frozen clock ignores FIFO accesses [RULE10]
	assign hostFifoWr = !fifoIdle && ((hostWr && fifoWrSel) ||
		(dmaAck && hostWr && fifoMode && !dirBack));
	assign hostFifoRd = !fifoIdle && ((hostRd && fifoRdSel) ||
		(dmaAck && hostRd && fifoMode && dirBack));
	assign fifoPush   = hostFifoWr || perPush;
	assign fifoPop    = hostFifoRd || perPop;
	// Command tag only for the address-FIFO port
	assign fifoIn     = perPush ? {feedAct, parallelDataLinesIn} :
		{(hostAddr == `ECPP_OFS_DATA && !dmaAck), hostWrData};
	assign leaving    = hostWr && hostAddr == `ECPP_OFS_EXTCTL &&
		fifoMode && hostWrData[7:5] != mode;
	assign fifoClear  = leaving; // [RULE14] [RULE8]

	ecpp_fifo u_fifo (
		.core_clk (core_clk),
		.reset    (reset),
		.clear    (fifoClear),
		.push     (fifoPush),
		.pushData (fifoIn),
		.pop      (fifoPop),
		.topData  (fifoTop),
		.empty    (fifoEmpty),
		.full     (fifoFull),
		.level    (fifoLevel)
	);

	// ----------------------------------------------------------------
	// Host register writes
	// ----------------------------------------------------------------
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ecpEnabled      <= 1'b0;
			portData        <= 8'h00;
			portControl     <= `ECPP_RST_CONTROL;
			extendedControl <= `ECPP_RST_EXTCTL;
			extendedIndex   <= 8'h00;
			extendedAux     <= 8'h00;
			secondCtl0      <= 8'h00;
			secondCtl2      <= 8'h00;
			secondCtl4      <= 8'h00;
			portSetupZero   <= 8'h00;
		end else begin
			// Strap sampled continuously; high bits pick ECP [RULE1]
			ecpEnabled <= (configMode[7:5] == `ECPP_CFG_ECP_A) ||
				(configMode[7:5] == `ECPP_CFG_ECP_B);
			if (hostWr && !dmaAck) begin
				if (hostAddr == `ECPP_OFS_DATA &&
					(mode == `ECPP_MODE_SPP ||
					mode == `ECPP_MODE_PS2)) begin
					portData <= hostWrData;
				end else if (hostAddr == `ECPP_OFS_CONTROL) begin
					portControl <= {2'b11, hostWrData[5:0]};
				end else if (hostAddr == `ECPP_OFS_EXTCTL) begin
					// Bits 1 and 0 are status, bit 2 takes the written value
					extendedControl <= {hostWrData[7:3],
						hostWrData[2], extendedControl[1:0]}; // [RULE1]
				end else if (hostAddr == `ECPP_OFS_EXTIDX) begin
					extendedIndex <= hostWrData;
				end else if (hostAddr == `ECPP_OFS_EXTAUX) begin
					extendedAux <= hostWrData;
				end else if (hostAddr == `ECPP_OFS_EXTDAT &&
					secondOn) begin
					if (extendedIndex == `ECPP_IDX_CTL0) begin
						secondCtl0 <= hostWrData; // [RULE22]
					end else if (extendedIndex == `ECPP_IDX_CTL2) begin
						secondCtl2 <= hostWrData;
					end else if (extendedIndex == `ECPP_IDX_CTL4) begin
						secondCtl4 <= hostWrData;
					end else if (extendedIndex ==
						`ECPP_IDX_SETUP0) begin
						portSetupZero <= hostWrData;
					end
				end
			end
			// Low bits mirror FIFO flags
			extendedControl[1] <= fifoFull;
			extendedControl[0] <= fifoEmpty;
			// Service bit set on burst stop; set wins over write
			if (burstStop) begin
				extendedControl[2] <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Host reads
	// ----------------------------------------------------------------
	assign statusByte = {!busyIn, ackIn_n, paperEndIn, selectIn,
		errIn_n, 3'b111};

	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			hostRdData <= 8'h00;
		end else if (hostRd) begin
			hostRdData <= 8'h00;
			if (dmaAck || (hostFifoRd && fifoRdSel)) begin
				hostRdData <= fifoTop[7:0];
			end else if (hostAddr == `ECPP_OFS_DATA &&
				(mode == `ECPP_MODE_SPP ||
				mode == `ECPP_MODE_PS2)) begin
				hostRdData <= parallelDataLinesIn; // [RULE25]
			end else if (hostAddr == `ECPP_OFS_STATUS) begin
				hostRdData <= statusByte;
			end else if (hostAddr == `ECPP_OFS_CONTROL) begin
				hostRdData <= portControl;
			end else if (hostAddr == `ECPP_OFS_FIFO &&
				mode == `ECPP_MODE_CONFIG) begin
				hostRdData <= {`ECPP_CAPA_HIGH, portSetupZero[7],
					`ECPP_CAPA_LOW};
			end else if (hostAddr == `ECPP_OFS_CAPB &&
				mode == `ECPP_MODE_CONFIG) begin
				hostRdData <= {6'h00, portSetupZero[1:0]};
			end else if (hostAddr == `ECPP_OFS_EXTCTL) begin
				if (clockFrozen) begin
					hostRdData <= {extendedControl[7:3], 
						`ECPP_PD_EXTLOW}; // [RULE11]
				end else begin
					hostRdData <= extendedControl;
				end
			end else if (hostAddr == `ECPP_OFS_EXTIDX) begin
				hostRdData <= extendedIndex;
			end else if (hostAddr == `ECPP_OFS_EXTAUX) begin
				hostRdData <= extendedAux;
			end else if (hostAddr == `ECPP_OFS_EXTDAT && secondOn) begin
				if (extendedIndex == `ECPP_IDX_CTL0) begin
					hostRdData <= secondCtl0; // [RULE22]
				end else if (extendedIndex == `ECPP_IDX_CTL2) begin
					hostRdData <= secondCtl2;
				end else if (extendedIndex == `ECPP_IDX_CTL4) begin
					hostRdData <= secondCtl4;
				end else if (extendedIndex == `ECPP_IDX_SETUP0) begin
					hostRdData <= portSetupZero;
				end
			end
		end
	end

	// Reads of extended control take wait states [RULE9]
	assign zeroWaitIndication = ecpEnabled && isEcpOfs && !dmaAck &&
		(hostWr || (hostRd && hostAddr != `ECPP_OFS_EXTCTL));
	assign ackIrqOnly = clockFrozen; // [RULE10]

	// ----------------------------------------------------------------
	// DMA request
	// ----------------------------------------------------------------
	assign wantDma = ecpEnabled && !clockFrozen && fifoMode &&
		extendedControl[`ECPP_XC_DMAEN] &&
		!extendedControl[`ECPP_XC_SVC] &&
		(dirBack ? !fifoEmpty : !fifoFull); // [RULE16] [RULE10]
	// Demand mode holds the request until four are pending
	// Burst end drops the request at once, before the service bit lands
	assign dmaReq = wantDma && !burstStop &&
		(!portSetupZero[`ECPP_SU_DEMAND] ||
		pendCnt >= `ECPP_DEMAND_CNT || dmaPhase); // [RULE18]

	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			burstCnt  <= 6'd0;
			burstStop <= 1'b0;
			pendCnt   <= 3'd0;
			dmaPhase  <= 1'b0;
		end else if (leaving) begin
			burstCnt  <= 6'd0; // [RULE14]
			burstStop <= 1'b0;
			pendCnt   <= 3'd0;
			dmaPhase  <= 1'b0;
		end else begin
			burstStop <= 1'b0;
			if (dmaAck && (hostRd || hostWr) && !fifoIdle) begin
				dmaPhase <= 1'b1;
				if (pendCnt != 3'd0) begin
					pendCnt <= pendCnt - 3'd1;
				end
				// Burst limit and terminal count end the run [RULE17]
				if (dmaTc || burstCnt == `ECPP_BURST_MAX - 6'd1) begin
					burstStop <= 1'b1;
					burstCnt  <= 6'd0;
					dmaPhase  <= 1'b0;
				end else begin
					burstCnt <= burstCnt + 6'd1;
				end
			end else if (!wantDma) begin
				dmaPhase <= 1'b0;
				pendCnt  <= 3'd0;
			end else if (!dmaPhase && pendCnt < `ECPP_DEMAND_CNT) begin
				pendCnt <= pendCnt + 3'd1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Peripheral ECP cycles
	// ----------------------------------------------------------------
	assign perPush = (state == ST_BDONE) && (rleCount == 8'h00);
	assign perPop  = (state == ST_FDONE);

	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state     <= ST_IDLE;
			settleCnt <= 3'd0;
			strobeAct <= 1'b0;
			feedAct   <= 1'b0;
			rleCount  <= 8'h00;
			parallelDataLinesOut <= 8'h00;
		end else if (leaving || !ecpEnabled) begin
			state     <= ST_IDLE; // [RULE8] [RULE14]
			strobeAct <= 1'b0;
			feedAct   <= 1'b0;
			rleCount  <= 8'h00;
		end else begin
			if (mode == `ECPP_MODE_SPP || mode == `ECPP_MODE_PS2) begin
				parallelDataLinesOut <= portData;
			end
			case (state)
			ST_IDLE: begin
				// Frozen clock blocks the next cycle [RULE12]
				if (!clockFrozen && fifoMode && !dirBack &&
					!fifoEmpty) begin
					parallelDataLinesOut <= fifoTop[7:0];
					feedAct   <= fifoTop[8];
					settleCnt <= 3'd0;
					state     <= ST_SETTLE;
				end else if (!clockFrozen && mode == `ECPP_MODE_ECP &&
					dirBack && !fifoFull) begin
					feedAct <= 1'b1;
					state   <= ST_BWAIT;
				end
			end
			ST_SETTLE: begin
				// Handshake not sampled until data settled [RULE21]
				if (settleCnt == `ECPP_SETTLE_CYC - 1) begin
					strobeAct <= 1'b1;
					state     <= ST_FWAIT;
				end else begin
					settleCnt <= settleCnt + 3'd1;
				end
			end
			ST_FWAIT: begin
				if (busyIn) begin
					strobeAct <= 1'b0;
					state     <= ST_FDONE;
				end
			end
			ST_FDONE: begin
				state <= ST_IDLE;
			end
			ST_BWAIT: begin
				if (!ackIn_n) begin
					feedAct <= 1'b0;
					state   <= ST_BDONE;
				end
			end
			ST_BDONE: begin
				state <= ST_IDLE;
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// Outputs idle unless ECP enabled [RULE13]
	assign strobeOut_n = !(ecpEnabled &&
		(strobeAct || portControl[0]));
	assign autoLineFeedLine_n = !(ecpEnabled &&
		(feedAct || portControl[1])); // [RULE8]
	assign initOut_n     = ecpEnabled ? portControl[2] : 1'b1;
	assign selectInOut_n = !(ecpEnabled && portControl[3]);
	assign parallelDataLinesOe = ecpEnabled && !dirBack; // [RULE24]
endmodule

//--- tb/ecpp_port_sva.sv
// Assertion checker for the parallel port control block
`timescale 1ns/100ps
module ecpp_port_sva (
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic [7:0]  configMode,
	input wire logic        clockFrozen,
	input wire logic [10:0] hostAddr,
	input wire logic        hostRd,
	input wire logic        hostWr,
	input wire logic        dmaAck,
	input wire logic        dmaTc,
	input wire logic [7:0]  hostRdData,
	input wire logic        zeroWaitIndication,
	input wire logic        dmaReq,
	input wire logic        ackIrqOnly,
	input wire logic        strobeOut_n,
	input wire logic        autoLineFeedLine_n,
	input wire logic        initOut_n,
	input wire logic        selectInOut_n
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	wire       ecpOn  = configMode[7:5] == 3'h4 || configMode[7:5] == 3'h7;
	wire       pio    = (hostRd || hostWr) && !dmaAck;
	wire       dmaCyc = (hostRd || hostWr) && dmaAck;
	wire       extRd  = hostRd && hostAddr == 11'h402;
	wire       ecpReg = hostAddr <= 11'h002 ||
		(hostAddr >= 11'h400 && hostAddr <= 11'h405);
	logic [6:0] burst;
	// Counts DMA cycles inside one unbroken request
	always @(posedge core_clk or posedge reset) begin
		if (reset)
			burst <= 7'h00;
		else if (!dmaReq)
			burst <= 7'h00;
		else if (dmaCyc)
			burst <= burst + 7'h01;
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	chk_zws_pio: assert property (pio && ecpOn && ecpReg && !extRd |->
		zeroWaitIndication)
		else $error("zero wait missing on port access");
	chk_zws_extrd: assert property (extRd |-> !zeroWaitIndication)
		else $error("zero wait on extended control read");
	chk_frozen_dma: assert property (clockFrozen |-> !dmaReq)
		else $error("DMA request while frozen");
	chk_irq_mask: assert property (ackIrqOnly == clockFrozen)
		else $error("interrupt mask does not follow freeze");
	chk_frozen_ext: assert property (pio && extRd && clockFrozen |=> hostRdData[2:0] == 3'h3)
		else $error("frozen extended control low bits wrong");
	chk_frozen_start: assert property (clockFrozen && $past(clockFrozen) |-> !$fell(strobeOut_n))
		else $error("peripheral cycle started while frozen");
	chk_idle_out: assert property (!ecpOn ##1 !ecpOn |-> strobeOut_n && autoLineFeedLine_n && initOut_n && selectInOut_n)
		else $error("peripheral outputs active while disabled");
	chk_burst_max: assert property (burst <= 7'd32)
		else $error("more than 32 consecutive DMA cycles");
	chk_tc_stop: assert property (dmaCyc && dmaTc |=> !dmaReq)
		else $error("DMA request after terminal count");
	cover property (dmaCyc && dmaTc);
	cover property (pio && hostWr && hostAddr == 11'h400);
	cover property (clockFrozen && extRd);
endmodule
bind ecpp_port ecpp_port_sva chk_u (.core_clk, .reset, .configMode,
	.clockFrozen, .hostAddr, .hostRd, .hostWr, .dmaAck, .dmaTc, .hostRdData,
	.zeroWaitIndication, .dmaReq, .ackIrqOnly, .strobeOut_n,
	.autoLineFeedLine_n, .initOut_n, .selectInOut_n);

//--- tb/ecpp_printer_model.sv
// Forward-direction printer model with a settable response delay
`timescale 1ns/100ps
module ecpp_printer_model (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       strobe_n,
	input  wire logic       stall,
	input  wire logic [3:0] slow,
	input  wire logic [7:0] lines,
	output logic            busy,
	output logic            ack_n,
	output logic            gotByte,
	output logic [7:0]      gotData
);
	logic [3:0] waitCnt;
	assign ack_n = 1'b1;
	// Byte is taken only when busy rises, so a stalled cycle delivers nothing
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			busy <= 1'b0;
			gotByte <= 1'b0;
			gotData <= 8'h00;
			waitCnt <= 4'h0;
		end else begin
			gotByte <= 1'b0;
			if (strobe_n) begin
				waitCnt <= 4'h0;
				busy <= 1'b0;
			end else if (!busy && !stall) begin
				waitCnt <= waitCnt + 4'h1;
				if (waitCnt >= slow) begin
					busy <= 1'b1;
					gotByte <= 1'b1;
					gotData <= lines;
				end
			end
		end
	end
endmodule

//--- tb/ecp_parallel_port_control_tb.sv
// Self-checking testbench of the parallel port control block
`timescale 1ns/100ps
`include "ecpp_defs.vh"
module ecp_parallel_port_control_tb;
	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  configMode = 8'h90;
	logic        baseAddr2 = 1'b1;
	logic        clockFrozen = 1'b0;
	logic [10:0] hostAddr = 11'h000;
	logic [7:0]  hostWrData = 8'h00;
	logic        hostRd = 1'b0;
	logic        hostWr = 1'b0;
	logic        dmaAck = 1'b0;
	logic        dmaTc = 1'b0;
	logic        stall = 1'b0;
	logic [3:0]  slow = 4'h0;
	logic        rdChk = 1'b0;
	logic        rdPend = 1'b0;
	logic [7:0]  lastOut = 8'h00;
	logic [7:0]  expRd[$];
	logic [7:0]  expPr[$];
	integer      error_cnt = 0;
	integer      checks_done = 0;
	integer      cycles = 0;
	wire [7:0]   hostRdData, parallelDataLinesOut, parallelDataLinesIn, gotData;
	wire         zeroWaitIndication, dmaReq, ackIrqOnly, parallelDataLinesOe;
	wire         strobeOut_n, autoLineFeedLine_n, initOut_n, selectInOut_n;
	wire         busyIn, ackIn_n, gotByte;
	// Undriven lines show the inverse of the last driven value
	assign parallelDataLinesIn = parallelDataLinesOe ? parallelDataLinesOut
		: ~lastOut;
	initial forever #20 core_clk = ~core_clk;
	ecpp_port dut_u (.core_clk, .reset, .configMode, .baseAddr2,
		.baseAddr10(1'b0), .clockFrozen, .hostAddr, .hostWrData, .hostRd,
		.hostWr, .dmaAck, .dmaTc, .hostRdData, .zeroWaitIndication, .dmaReq,
		.ackIrqOnly, .parallelDataLinesIn, .parallelDataLinesOut,
		.parallelDataLinesOe, .busyIn, .ackIn_n, .errIn_n(1'b1),
		.selectIn(1'b1), .paperEndIn(1'b0), .strobeOut_n,
		.autoLineFeedLine_n, .initOut_n, .selectInOut_n);
	ecpp_printer_model prn_u (.core_clk, .reset, .strobe_n(strobeOut_n),
		.stall, .slow, .lines(parallelDataLinesIn), .busy(busyIn), .ack_n(ackIn_n),
		.gotByte, .gotData);
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task check(input logic [7:0] e, input logic [7:0] g);
		checks_done = checks_done + 1;
		if (g !== e) begin
			error_cnt = error_cnt + 1;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task end_of_test;
		if (error_cnt == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task wr(input logic [10:0] a, input logic [7:0] d, input logic dma = 0,
		input logic tc = 0);
		@(posedge core_clk);
		hostAddr <= a;
		hostWrData <= d;
		hostWr <= 1'b1;
		dmaAck <= dma;
		dmaTc <= tc;
		@(posedge core_clk);
		hostWr <= 1'b0;
		dmaAck <= 1'b0;
		dmaTc <= 1'b0;
	endtask
	task rd(input logic [10:0] a, input logic [7:0] e, input logic c = 1);
		if (c)
			expRd.push_back(e);
		@(posedge core_clk);
		hostAddr <= a;
		hostRd <= 1'b1;
		rdChk <= c;
		@(posedge core_clk);
		hostRd <= 1'b0;
	endtask
	task waitPr;
		for (int i = 0; i < 3000 && (expPr.size() != 0 || busyIn); i++)
			@(posedge core_clk);
	endtask
	// ----------------------------------------------------------------
	// Result watcher
	// ----------------------------------------------------------------
	always @(posedge core_clk) begin
		if (parallelDataLinesOe)
			lastOut <= parallelDataLinesOut;
		rdPend <= hostRd && rdChk;
		if (rdPend)
			check(expRd.pop_front(), hostRdData);
		if (gotByte)
			check(expPr.pop_front(), gotData);
		cycles = cycles + 1;
		if (cycles == 20000) begin
			error_cnt = error_cnt + 1;
			end_of_test;
		end
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] d;
		logic [7:0] q[$];
		void'($urandom(10492));
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		rd(11'h402, `ECPP_RST_EXTCTL);
		rd(11'h002, `ECPP_RST_CONTROL);
		wr(11'h002, 8'h04);
		rd(11'h002, 8'hC4);
		wr(11'h403, 8'h05);
		wr(11'h404, 8'h80);
		rd(11'h404, 8'h80);
		wr(11'h402, 8'hE0);
		rd(11'h400, 8'h1C);
		rd(11'h406, 8'h00, 0);
		wr(11'h402, 8'h00);
		wr(11'h402, 8'h80);
		wr(11'h002, 8'h04);
		rd(11'h001, 8'hDF);
		wr(11'h402, 8'h00);
		wr(11'h402, 8'h40);
		slow <= 4'($urandom_range(6));
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom);
			expPr.push_back(d);
			wr(11'h400, d);
		end
		waitPr();
		rd(11'h402, 8'h41);
		stall <= 1'b1;
		for (int i = 0; i < 3; i++)
			wr(11'h400, 8'($urandom));
		wr(11'h402, 8'h00);
		rd(11'h402, 8'h01);
		stall <= 1'b0;
		wr(11'h402, 8'hC0);
		for (int i = 0; i < 17; i++) begin
			d = 8'($urandom);
			if (i < 16)
				q.push_back(d);
			wr(11'h400, d);
		end
		wr(11'h000, 8'h3C);
		rd(11'h402, 8'hC2);
		clockFrozen <= 1'b1;
		rd(11'h402, 8'hC3);
		rd(11'h400, 8'h00, 0);
		clockFrozen <= 1'b0;
		rd(11'h402, 8'hC2);
		for (int i = 0; i < 16; i++)
			rd(11'h400, q[i]);
		rd(11'h402, 8'hC1);
		wr(11'h402, 8'h00);
		wr(11'h402, 8'h48);
		slow <= 4'($urandom_range(6));
		for (int i = 0; i < 6; i++) begin
			for (int k = 0; k < 200 && dmaReq !== 1'b1; k++)
				@(posedge core_clk);
			d = 8'($urandom);
			expPr.push_back(d);
			wr(11'h400, d, 1'b1, i == 5);
		end
		waitPr();
		wr(11'h402, 8'h00);
		reset <= 1'b1;
		configMode <= 8'h00;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		repeat (3) @(posedge core_clk);
		check(8'h0F, {4'h0, strobeOut_n, autoLineFeedLine_n, initOut_n,
			selectInOut_n});
		end_of_test;
	end
endmodule
